// [operand_address_mode_decoder.sv]
// Overview of operation
// - inherent mode is one opcode byte, no operand bytes fetched
// - immediate mode fetches one byte used directly as operand
// - short direct fetches one address byte, reach 00 to ff
// - long direct fetches two address bytes, full 64 kbyte reach
// - indexed address is unsigned sum of chosen index and offset
// - indexed no offset fetches nothing, address is index value
// - short indexed adds one offset byte, reach 00 to 1fe
// - long indexed adds two-byte offset, full 64 kbyte reach
// - indirect reads a pointer, then uses it as operand address
// - byte after opcode is the pointer location in indirect modes
// - short indirect reads a one-byte pointer, reach 00 to ff
// - long indirect reads a two-byte pointer, full 64 kbyte reach
// - short sub-modes reach page zero, 00 to 1fe when indexed, shorter and faster
// - long sub-modes reach full space, more bytes and cycles
// - read-modify-write instructions accept short sub-modes only
// - seventeen modes grouped in seven families are supported
// - relative adds signed 8-bit offset to program counter
`timescale 1ns/1ps
`default_nettype none

module operand_address_mode_decoder
    import amode_pkg::*;
(
    input  wire logic                     sys_clk_in,
    input  wire logic                     rst_n_in,
    input  wire logic                     start_in,
    input  wire amode_pkg::decode_req_type req_in,
    output logic                          busy_out,
    output logic                          done_out,
    output amode_pkg::decode_rsp_type     rsp_out,
    output logic                          mem_rd_out,
    output logic [15:0]                   mem_addr_out,
    input  wire logic                     mem_ack_in,
    input  wire logic [7:0]               mem_data_in
);
    import amode_pkg::*;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_ARG_H = 6'h02,
        ST_ARG_L = 6'h04,
        ST_PTR_H = 6'h08,
        ST_PTR_L = 6'h10,
        ST_DONE  = 6'h20
    } state_type;

    state_type      state_reg;
    state_type      state_next;
    decode_req_type req_reg;
    logic [15:0]    fetch_pc_reg;
    logic [7:0]     arg_hi_reg;
    logic [7:0]     arg_lo_reg;
    logic [7:0]     ptr_hi_reg;
    logic [7:0]     ptr_lo_reg;
    logic [15:0]    ptr_addr_reg;
    logic [2:0]     args_reg;
    decode_rsp_type rsp_reg;
    logic           done_reg;

    // bytes after the opcode for each mode
    function automatic logic [2:0] arg_bytes(input amode_type m);
        unique case (m)
            MODE_INHERENT, MODE_IDX_NOOFS: arg_bytes = 3'h0;
            MODE_IMMEDIATE, MODE_DIR_SHORT, MODE_IDX_SHORT,
            MODE_REL_DIRECT, MODE_BIT_DIRECT: arg_bytes = 3'h1;
            MODE_DIR_LONG, MODE_IDX_LONG, MODE_IND_SHORT, MODE_IND_LONG,
            MODE_INDIDX_SHORT, MODE_INDIDX_LONG, MODE_REL_INDIRECT,
            MODE_BIT_INDIRECT, MODE_BITREL_DIRECT: arg_bytes = 3'h2;
            MODE_BITREL_IND: arg_bytes = 3'h3;
            default: arg_bytes = 3'h0;
        endcase
    endfunction : arg_bytes

    // bytes read from the instruction stream itself (pointer modes: 1)
    function automatic logic [1:0] stream_bytes(input amode_type m);
        unique case (m)
            MODE_DIR_LONG, MODE_IDX_LONG: stream_bytes = 2'h2;
            MODE_INHERENT, MODE_IDX_NOOFS: stream_bytes = 2'h0;
            default: stream_bytes = 2'h1;
        endcase
    endfunction : stream_bytes

    function automatic logic [1:0] ptr_bytes(input amode_type m);
        unique case (m)
            MODE_IND_LONG, MODE_INDIDX_LONG: ptr_bytes = 2'h2;
            MODE_IND_SHORT, MODE_INDIDX_SHORT, MODE_REL_INDIRECT,
            MODE_BIT_INDIRECT, MODE_BITREL_IND: ptr_bytes = 2'h1;
            default: ptr_bytes = 2'h0;
        endcase
    endfunction : ptr_bytes

    function automatic logic is_long(input amode_type m);
        is_long = (m == MODE_DIR_LONG) || (m == MODE_IDX_LONG) ||
                  (m == MODE_IND_LONG) || (m == MODE_INDIDX_LONG);
    endfunction : is_long

    function automatic logic is_indexed(input amode_type m);
        is_indexed = (m == MODE_IDX_NOOFS) || (m == MODE_IDX_SHORT) ||
                     (m == MODE_IDX_LONG) || (m == MODE_INDIDX_SHORT) ||
                     (m == MODE_INDIDX_LONG);
    endfunction : is_indexed

    logic       start_ok;
    logic       illegal_mode;
    logic [7:0] idx_sel;
    logic [15:0] base_val;
    logic [15:0] ptr_val;
    logic [15:0] ea_calc;
    logic [15:0] tgt_calc;

    // rmw on memory only with short sub-modes; refused, flagged illegal
    assign illegal_mode = (req_in.rmw && is_long(req_in.mode)) ||
                          (5'(req_in.mode) >= 5'(MODE_COUNT));
    assign start_ok     = start_in && (state_reg == ST_IDLE);
    assign busy_out     = (state_reg != ST_IDLE);
    assign done_out     = done_reg;
    assign rsp_out      = rsp_reg;
    assign mem_rd_out   = (state_reg == ST_ARG_H) || (state_reg == ST_ARG_L)
                       || (state_reg == ST_PTR_H) || (state_reg == ST_PTR_L);

    always_comb begin
        unique case (state_reg)
            ST_ARG_H, ST_ARG_L: mem_addr_out = fetch_pc_reg;
            ST_PTR_H: mem_addr_out = ptr_addr_reg;
            // a byte pointer sits at the location itself, a word's low half
            // one above it
            ST_PTR_L: mem_addr_out = (ptr_bytes(req_reg.mode) == 2'h2) ?
                                     16'(ptr_addr_reg + 16'h0001) :
                                     ptr_addr_reg;
            default:  mem_addr_out = RESET_ADDR;
        endcase
    end

    // fetch sequencer: stream bytes first, then pointer bytes
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (start_ok && !illegal_mode) begin
                    unique case (stream_bytes(req_in.mode))
                        2'h2:    state_next = ST_ARG_H;
                        2'h1:    state_next = ST_ARG_L;
                        default: state_next = ST_DONE;
                    endcase
                end else if (start_ok) begin
                    state_next = ST_DONE;
                end
            end
            ST_ARG_H: if (mem_ack_in) state_next = ST_ARG_L;
            ST_ARG_L: begin
                if (mem_ack_in) begin
                    unique case (ptr_bytes(req_reg.mode))
                        2'h2:    state_next = ST_PTR_H;
                        2'h1:    state_next = ST_PTR_L;
                        default: state_next = ST_DONE;
                    endcase
                end
            end
            ST_PTR_H: if (mem_ack_in) state_next = ST_PTR_L;
            ST_PTR_L: if (mem_ack_in) state_next = ST_DONE;
            ST_DONE:  state_next = ST_IDLE;
            default:  state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            req_reg      <= '0;
            fetch_pc_reg <= RESET_PC;
            args_reg     <= 3'h0;
        end else if (start_ok) begin
            req_reg      <= req_in;
            fetch_pc_reg <= 16'(req_in.pc + 16'h0001);
            args_reg     <= arg_bytes(req_in.mode);
        end else if (mem_ack_in && ((state_reg == ST_ARG_H) ||
                                    (state_reg == ST_ARG_L))) begin
            fetch_pc_reg <= 16'(fetch_pc_reg + 16'h0001);
        end
    end

    // operand bytes; short forms leave the high byte zero (page zero)
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            arg_hi_reg <= 8'h00;
            arg_lo_reg <= 8'h00;
            ptr_hi_reg <= 8'h00;
            ptr_lo_reg <= 8'h00;
        end else if (start_ok) begin
            arg_hi_reg <= 8'h00;
            arg_lo_reg <= 8'h00;
            ptr_hi_reg <= 8'h00;
            ptr_lo_reg <= 8'h00;
        end else if (mem_ack_in) begin
            if (state_reg == ST_ARG_H) arg_hi_reg <= mem_data_in;
            if (state_reg == ST_ARG_L) arg_lo_reg <= mem_data_in;
            if (state_reg == ST_PTR_H) ptr_hi_reg <= mem_data_in;
            if (state_reg == ST_PTR_L) ptr_lo_reg <= mem_data_in;
        end
    end

    // pointer lives in page zero at the address given by the byte after the opcode
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            ptr_addr_reg <= PAGE_ZERO_BASE;
        end else if (state_reg == ST_ARG_L && mem_ack_in) begin
            ptr_addr_reg <= {PAGE_ZERO_BASE[15:8], mem_data_in};
        end
    end

    assign idx_sel  = req_reg.use_y ? req_reg.idx_y : req_reg.idx_x;
    assign base_val = {arg_hi_reg, arg_lo_reg};
    assign ptr_val  = {ptr_hi_reg, ptr_lo_reg};

    // effective address per mode; 16-bit wrap on long indexed sums
    always_comb begin
        unique case (req_reg.mode)
            MODE_DIR_SHORT, MODE_BIT_DIRECT, MODE_BITREL_DIRECT:
                ea_calc = {8'h00, arg_lo_reg};
            MODE_DIR_LONG:   ea_calc = base_val;
            MODE_IDX_NOOFS:  ea_calc = {8'h00, idx_sel};
            MODE_IDX_SHORT:  ea_calc = 16'({8'h00, arg_lo_reg}) +
                                       16'({8'h00, idx_sel});
            MODE_IDX_LONG:   ea_calc = 16'(base_val +
                                       {8'h00, idx_sel});
            MODE_IND_SHORT, MODE_BIT_INDIRECT, MODE_BITREL_IND:
                ea_calc = ptr_val;
            MODE_IND_LONG:   ea_calc = ptr_val;
            MODE_INDIDX_SHORT, MODE_INDIDX_LONG:
                ea_calc = 16'(ptr_val + {8'h00, idx_sel});
            default:         ea_calc = RESET_ADDR;
        endcase
    end

    // branch target: signed 8-bit offset on the address after the last stream byte fetched
    always_comb begin
        tgt_calc = RESET_PC;
        if (req_reg.mode == MODE_REL_DIRECT) begin
            tgt_calc = 16'(fetch_pc_reg +
                           {{8{arg_lo_reg[7]}}, arg_lo_reg});
        end else if (req_reg.mode == MODE_REL_INDIRECT) begin
            tgt_calc = 16'(fetch_pc_reg +
                           {{8{ptr_lo_reg[7]}}, ptr_lo_reg});
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            rsp_reg  <= '0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= (state_reg == ST_DONE);
            if (state_reg == ST_DONE) begin
                rsp_reg.ea      <= ea_calc;
                rsp_reg.target  <= tgt_calc;
                rsp_reg.operand <= arg_lo_reg;
                rsp_reg.is_imm  <= (req_reg.mode == MODE_IMMEDIATE);
                rsp_reg.length  <= 3'(args_reg + 3'h1);
                rsp_reg.illegal <= (req_reg.rmw && is_long(req_reg.mode))
                                || (5'(req_reg.mode) >= 5'(MODE_COUNT));
            end
        end
    end

    logic unused_ok;
    assign unused_ok = is_indexed(req_reg.mode);

    property p_inherent_no_fetch;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (start_ok && req_in.mode == MODE_INHERENT) |=> ##1 done_out
            && rsp_out.length == 3'h1;
    endproperty
    a_inherent_no_fetch: assert property (p_inherent_no_fetch)
        else $error("inherent length wrong");

    property p_imm_flag;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (done_out && rsp_out.is_imm) |-> rsp_out.length == 3'h2;
    endproperty
    a_imm_flag: assert property (p_imm_flag)
        else $error("immediate length wrong");

    property p_short_dir_page0;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (state_reg == ST_DONE && req_reg.mode == MODE_DIR_SHORT)
            |=> rsp_out.ea[15:8] == 8'h00;
    endproperty
    a_short_dir_page0: assert property (p_short_dir_page0)
        else $error("short direct left page zero");

    property p_idx_short_range;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (state_reg == ST_DONE && req_reg.mode == MODE_IDX_SHORT)
            |=> rsp_out.ea <= 16'h01fe;
    endproperty
    a_idx_short_range: assert property (p_idx_short_range)
        else $error("short indexed out of range");

    property p_ptr_in_page0;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (state_reg == ST_PTR_H || state_reg == ST_PTR_L)
            |-> mem_addr_out[15:9] == 7'h00;
    endproperty
    a_ptr_in_page0: assert property (p_ptr_in_page0)
        else $error("pointer not in page zero");

    property p_ptr_before_done;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (state_reg == ST_PTR_L && !mem_ack_in) |=> state_reg != ST_DONE;
    endproperty
    a_ptr_before_done: assert property (p_ptr_before_done)
        else $error("operand before pointer fetch");

    property p_rmw_long_illegal;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (start_ok && req_in.rmw && is_long(req_in.mode))
            |=> ##1 done_out && rsp_out.illegal;
    endproperty
    a_rmw_long_illegal: assert property (p_rmw_long_illegal)
        else $error("rmw long mode not refused");

    property p_long_hi_first;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (state_reg == ST_ARG_H && mem_ack_in)
            |=> arg_hi_reg == $past(mem_data_in) && state_reg == ST_ARG_L;
    endproperty
    a_long_hi_first: assert property (p_long_hi_first)
        else $error("high byte not first");

    c_long_indirect: cover property (@(posedge sys_clk_in)
        state_reg == ST_PTR_H ##[1:20] done_out);
    c_idx_long: cover property (@(posedge sys_clk_in)
        done_out && req_reg.mode == MODE_IDX_LONG);
    c_rel: cover property (@(posedge sys_clk_in)
        done_out && req_reg.mode == MODE_REL_DIRECT);

endmodule : operand_address_mode_decoder

`default_nettype wire

// [amode_pkg.sv]
package amode_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    // 17 addressing modes in 7 families
    localparam int MODE_COUNT   = 17;
    localparam int FAMILY_COUNT = 7;

    typedef enum logic [4:0] {
        MODE_INHERENT      = 5'h00,
        MODE_IMMEDIATE     = 5'h01,
        MODE_DIR_SHORT     = 5'h02,
        MODE_DIR_LONG      = 5'h03,
        MODE_IDX_NOOFS     = 5'h04,
        MODE_IDX_SHORT     = 5'h05,
        MODE_IDX_LONG      = 5'h06,
        MODE_IND_SHORT     = 5'h07,
        MODE_IND_LONG      = 5'h08,
        MODE_INDIDX_SHORT  = 5'h09,
        MODE_INDIDX_LONG   = 5'h0a,
        MODE_REL_DIRECT    = 5'h0b,
        MODE_REL_INDIRECT  = 5'h0c,
        MODE_BIT_DIRECT    = 5'h0d,
        MODE_BIT_INDIRECT  = 5'h0e,
        MODE_BITREL_DIRECT = 5'h0f,
        MODE_BITREL_IND    = 5'h10
    } amode_type;

    localparam logic [15:0] PAGE_ZERO_BASE = 16'h0000;
    localparam logic [15:0] RESET_ADDR     = 16'h0000;
    localparam logic [15:0] RESET_PC       = 16'h0000;

    typedef struct packed {
        amode_type   mode;
        logic        use_y;
        logic        rmw;
        logic [15:0] pc;
        logic [7:0]  idx_x;
        logic [7:0]  idx_y;
    } decode_req_type;

    typedef struct packed {
        logic [15:0] ea;
        logic [15:0] target;
        logic [7:0]  operand;
        logic        is_imm;
        logic [2:0]  length;
        logic        illegal;
    } decode_rsp_type;

endpackage : amode_pkg

// [partner_memory.sv]
`timescale 1ns/1ps
`default_nettype none

module partner_memory (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        mem_rd_in,
    input  wire logic [15:0] mem_addr_in,
    input  wire logic [1:0]  wait_in,
    output logic             mem_ack_out,
    output logic [7:0]       mem_data_out
);
    logic [1:0] stall_reg;
    logic [7:0] last_reg;

    // contents follow the address so every byte is predictable
    assign mem_ack_out = mem_rd_in && (stall_reg == wait_in);
    // off the ack the bus shows the inverse of the last byte, never stale data
    assign mem_data_out = mem_ack_out ? (mem_addr_in[7:0] + 8'h21)
                                      : ~last_reg;

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in || !mem_rd_in || mem_ack_out) begin
            stall_reg <= 2'h0;
        end else begin
            stall_reg <= stall_reg + 2'h1;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            last_reg <= 8'h00;
        end else if (mem_ack_out) begin
            last_reg <= mem_data_out;
        end
    end
endmodule : partner_memory

`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import amode_pkg::*;

    typedef struct packed {
        amode_type   mode;
        logic [2:0]  flg;   // skip fetch check, use_y, rmw
        logic [2:0]  len;   // 0: not compared
        logic        ill;
        logic [1:0]  nf;
        logic [1:0]  kind;  // 1 ea, 2 target, 3 operand
        logic [15:0] val;
        logic [15:0] a1;
    } row_type;

    localparam logic [15:0] PC = 16'h12fd;

    logic           sys_clk_in;
    logic           rst_n_in;
    logic           start_in;
    decode_req_type req_in;
    logic           busy_out;
    logic           done_out;
    decode_rsp_type rsp_out;
    logic           mem_rd_out;
    logic [15:0]    mem_addr_out;
    logic           mem_ack_in;
    logic [7:0]     mem_data_in;
    logic [1:0]     wait_sel;
    logic [15:0]    log_addr [4];
    int             log_n;
    int             error_cnt;
    int             checks;
    row_type        rows [22];

    operand_address_mode_decoder dut_u (
        .sys_clk_in  (sys_clk_in),
        .rst_n_in    (rst_n_in),
        .start_in    (start_in),
        .req_in      (req_in),
        .busy_out    (busy_out),
        .done_out    (done_out),
        .rsp_out     (rsp_out),
        .mem_rd_out  (mem_rd_out),
        .mem_addr_out(mem_addr_out),
        .mem_ack_in  (mem_ack_in),
        .mem_data_in (mem_data_in)
    );

    partner_memory mem_u (
        .sys_clk_in  (sys_clk_in),
        .rst_n_in    (rst_n_in),
        .mem_rd_in   (mem_rd_out),
        .mem_addr_in (mem_addr_out),
        .wait_in     (wait_sel),
        .mem_ack_out (mem_ack_in),
        .mem_data_out(mem_data_in)
    );

    always #50 sys_clk_in = ~sys_clk_in;

    // the log restarts on the edge that takes a request
    always @(posedge sys_clk_in) begin
        if (start_in === 1'b1 && busy_out === 1'b0) begin
            log_n <= 0;
        end else if (mem_rd_out === 1'b1 && mem_ack_in === 1'b1 &&
                     log_n < 4) begin
            log_addr[log_n] <= mem_addr_out;
            log_n <= log_n + 1;
        end
    end

    task automatic complete_run();
        if (error_cnt == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_bit

    task automatic idle_check();
        cmp_bit(busy_out, 1'b0);
        cmp_bit(done_out, 1'b0);
        cmp_bit(mem_rd_out, 1'b0);
        cmp_word(mem_addr_out, 16'h0000);
        cmp_word(rsp_out.ea, 16'h0000);
    endtask : idle_check

    // called at a falling edge; start is held one extra busy cycle with a
    // junk request, which the design must ignore
    task automatic run_op(input row_type r, input logic [15:0] pc);
        int n;
        n = 0;
        start_in = 1'b1;
        req_in = '{r.mode, r.flg[1], r.flg[0], pc, 8'hf0, 8'h37};
        // done of the previous call may still stand here, so wait first
        do begin
            @(negedge sys_clk_in);
            n++;
            if (n == 1) req_in = '{MODE_INHERENT, 1'b0, 1'b0, 16'h0,
                                   8'h0, 8'h0};
            if (n == 2) start_in = 1'b0;
        end while (n < 60 && done_out !== 1'b1);
        if (done_out !== 1'b1) begin
            error_cnt++;
            complete_run();
        end
        start_in = 1'b0;
        cmp_bit(rsp_out.illegal, r.ill);
        if (r.len != 3'h0) cmp_word(rsp_out.length, r.len);
        if (!r.flg[2]) begin
            cmp_word(16'(log_n), {14'h0, r.nf});
            cmp_word(16'(n), 16'(2 + r.nf * (1 + wait_sel)));
            if (r.nf > 0) cmp_word(log_addr[0], pc + 16'h1);
            if (r.nf > 1) cmp_word(log_addr[1], r.a1);
            if (r.nf > 2) cmp_word(log_addr[2], r.a1 + 16'h1);
        end
        if (r.kind == 2'h1) cmp_word(rsp_out.ea, r.val);
        if (r.kind == 2'h2) cmp_word(rsp_out.target, r.val);
        if (r.kind == 2'h3) cmp_word(rsp_out.operand, r.val);
        if (r.kind == 2'h3) cmp_bit(rsp_out.is_imm, 1'b1);
    endtask : run_op

    initial begin
        sys_clk_in = 1'b0;
        rst_n_in = 1'b0;
        start_in = 1'b0;
        req_in = '0;
        wait_sel = 2'h0;
        error_cnt = 0;
        checks = 0;
        rows = '{
        '{MODE_INHERENT, 3'h0, 3'h1, 1'b0, 2'h0, 2'h0, 16'h0000, 16'h0000},
        '{MODE_IMMEDIATE, 3'h0, 3'h2, 1'b0, 2'h1, 2'h3, 16'h001f, 16'h0000},
        '{MODE_DIR_SHORT, 3'h0, 3'h2, 1'b0, 2'h1, 2'h1, 16'h001f, 16'h0000},
        '{MODE_DIR_LONG, 3'h0, 3'h3, 1'b0, 2'h2, 2'h1, 16'h1f20, 16'h12ff},
        '{MODE_IDX_NOOFS, 3'h0, 3'h1, 1'b0, 2'h0, 2'h1, 16'h00f0, 16'h0000},
        '{MODE_IDX_NOOFS, 3'h2, 3'h1, 1'b0, 2'h0, 2'h1, 16'h0037, 16'h0000},
        '{MODE_IDX_SHORT, 3'h0, 3'h2, 1'b0, 2'h1, 2'h1, 16'h010f, 16'h0000},
        '{MODE_IDX_LONG, 3'h2, 3'h3, 1'b0, 2'h2, 2'h1, 16'h1f57, 16'h12ff},
        '{MODE_IND_SHORT, 3'h0, 3'h3, 1'b0, 2'h2, 2'h1, 16'h0040, 16'h001f},
        '{MODE_IND_LONG, 3'h0, 3'h3, 1'b0, 2'h3, 2'h1, 16'h4041, 16'h001f},
        '{MODE_INDIDX_SHORT, 3'h0, 3'h3, 1'b0, 2'h2, 2'h1, 16'h0130, 16'h001f},
        '{MODE_INDIDX_LONG, 3'h2, 3'h3, 1'b0, 2'h3, 2'h1, 16'h4078, 16'h001f},
        '{MODE_REL_DIRECT, 3'h0, 3'h2, 1'b0, 2'h1, 2'h2, 16'h131e, 16'h0000},
        '{MODE_REL_INDIRECT, 3'h0, 3'h3, 1'b0, 2'h2, 2'h2, 16'h133f, 16'h001f},
        '{MODE_BIT_DIRECT, 3'h0, 3'h2, 1'b0, 2'h1, 2'h1, 16'h001f, 16'h0000},
        '{MODE_BIT_INDIRECT, 3'h0, 3'h3, 1'b0, 2'h2, 2'h1, 16'h0040, 16'h001f},
        '{MODE_BITREL_DIRECT, 3'h0, 3'h3, 1'b0, 2'h1, 2'h1, 16'h001f, 16'h0000},
        '{MODE_BITREL_IND, 3'h0, 3'h4, 1'b0, 2'h2, 2'h1, 16'h0040, 16'h001f},
        '{MODE_DIR_SHORT, 3'h1, 3'h2, 1'b0, 2'h1, 2'h1, 16'h001f, 16'h0000},
        '{MODE_DIR_LONG, 3'h1, 3'h0, 1'b1, 2'h0, 2'h0, 16'h0000, 16'h0000},
        '{MODE_IDX_LONG, 3'h1, 3'h0, 1'b1, 2'h0, 2'h0, 16'h0000, 16'h0000},
        '{MODE_IND_LONG, 3'h1, 3'h0, 1'b1, 2'h0, 2'h0, 16'h0000, 16'h0000}};
        repeat (10) @(negedge sys_clk_in);
        idle_check();
        rst_n_in = 1'b1;
        for (int w = 0; w < 4; w += 2) begin
            wait_sel = 2'(w);
            foreach (rows[i]) run_op(rows[i], PC);
        end
        // negative relative offset: 1272 + ff92 wraps down to 1204
        run_op('{MODE_REL_DIRECT, 3'h0, 3'h2, 1'b0, 2'h1, 2'h2, 16'h1204,
                 16'h0000}, 16'h1270);
        // an unused mode code is refused with no fetch
        run_op('{amode_type'(5'h11), 3'h0, 3'h0, 1'b1, 2'h0, 2'h0, 16'h0,
                 16'h0}, PC);
        // reset in the middle of the slow fetch of the byte after the opcode, before any pointer byte
        start_in = 1'b1;
        req_in = '{MODE_IND_LONG, 1'b0, 1'b0, PC, 8'hf0, 8'h37};
        @(negedge sys_clk_in);
        start_in = 1'b0;
        repeat (2) @(negedge sys_clk_in);
        rst_n_in = 1'b0;
        @(negedge sys_clk_in);
        idle_check();
        rst_n_in = 1'b1;
        run_op(rows[9], PC);
        complete_run();
    end
endmodule : testbench

`default_nettype wire
